// ---- core/periodic_timer.v ----
// Ten-bit periodic timer with APB register access
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "periodic_timer_regs.vh"

module periodic_timer #(
    parameter integer SUB_DIV = 305
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        external_count_pin,
    input  wire        capture_input_pin,
    output reg         timer_output_pin,
    output reg         compare_a_flag,
    output reg         compare_p_flag
);
    reg  [7:0] run_q;
    reg  [7:0] mode_q;
    reg  [9:0] count_q;
    reg  [9:0] cmp_a_q;
    reg  [9:0] period_q;
    reg        level_q;
    reg        on_prev_q;
    reg  [2:0] ck_sync_q;
    reg  [2:0] cap_sync_q;
    reg        ck_stable_q;
    reg        cap_stable_q;
    reg  [9:0] pre_q;
    reg  [9:0] sub_q;

    wire       wr_en = psel & penable & pwrite;
    wire       paused = run_q[`BIT_PAUSE];
    wire       on = run_q[`BIT_ON];
    wire [2:0] ck_sel = run_q[6:4];
    wire [1:0] mode = mode_q[7:6];
    wire [1:0] pin_fn = mode_q[5:4];
    wire       lvl = mode_q[`BIT_OUT_LEVEL];
    wire       inv = mode_q[`BIT_INVERT];
    wire       on_rise = on & ~on_prev_q;

    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Three-stage sync; change taken once stages two and three agree
    wire ck_agree = ck_sync_q[1] == ck_sync_q[2];
    wire cap_agree = cap_sync_q[1] == cap_sync_q[2];
    wire ck_rise = ck_agree & ck_sync_q[2] & ~ck_stable_q;
    wire ck_fall = ck_agree & ~ck_sync_q[2] & ck_stable_q;
    wire cap_rise = cap_agree & cap_sync_q[2] & ~cap_stable_q;
    wire cap_fall = cap_agree & ~cap_sync_q[2] & cap_stable_q;

    always @(posedge clk) begin
        if (rst) begin
            ck_sync_q <= 3'h0;
            cap_sync_q <= 3'h0;
            ck_stable_q <= 1'b0;
            cap_stable_q <= 1'b0;
        end else begin
            ck_sync_q <= {ck_sync_q[1:0], external_count_pin};
            cap_sync_q <= {cap_sync_q[1:0], capture_input_pin};
            if (ck_agree) ck_stable_q <= ck_sync_q[2];
            if (cap_agree) cap_stable_q <= cap_sync_q[2];
        end
    end

    // Internal clocks as enables; high clock is taken as the system clock
    function [9:0] div_of;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    div_of = `DIV_SYS;
                3'h2:    div_of = `DIV_HIGH_16;
                3'h3:    div_of = `DIV_HIGH_64;
                default: div_of = 10'h001;
            endcase
        end
    endfunction

    wire pre_tick = (pre_q >= div_of(ck_sel) - 10'h001);
    wire sub_tick = (sub_q >= SUB_DIV[9:0] - 10'h001);
    reg  tick;
    always @* begin
        case (ck_sel)
            3'h4:    tick = sub_tick;
            3'h6:    tick = ck_rise;
            3'h7:    tick = ck_fall;
            3'h1,
            3'h5:    tick = 1'b1;
            default: tick = pre_tick;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            pre_q <= 10'h000;
            sub_q <= 10'h000;
        end else begin
            pre_q <= pre_tick ? 10'h000 : pre_q + 10'h001;
            sub_q <= sub_tick ? 10'h000 : sub_q + 10'h001;
        end
    end

    // Comparators run continuously
    wire match_a = (count_q == cmp_a_q);
    wire match_p = (count_q == period_q);
    wire overflow = (count_q == 10'h3FF);
    wire pwm_like = (mode == `MODE_PWM);
    // Period of zero means full 1024 counts, which is plain overflow
    wire end_p = (period_q == 10'h000) ? overflow : (count_q == period_q - 10'h001);
    wire step = on & ~paused & tick;

    reg clr_now;
    always @* begin
        case (mode)
            `MODE_COMPARE,
            `MODE_TIMER: clr_now = mode_q[`BIT_CLR_SEL] ? match_a :
                                   ((period_q == 10'h000) ? overflow : match_p);
            // Single pulse runs on until the A match drops counter-on
            `MODE_PWM:   clr_now = (pin_fn == 2'h3) ? 1'b0 : end_p;
            default:     clr_now = (period_q == 10'h000) ? overflow : match_p;
        endcase
    end

    reg cap_edge;
    always @* begin
        case (pin_fn)
            2'h0:    cap_edge = mode_q[`BIT_CAP_SRC] ? ck_rise : cap_rise;
            2'h1:    cap_edge = mode_q[`BIT_CAP_SRC] ? ck_fall : cap_fall;
            2'h2:    cap_edge = mode_q[`BIT_CAP_SRC] ? (ck_rise | ck_fall)
                                                     : (cap_rise | cap_fall);
            default: cap_edge = 1'b0;
        endcase
    end
    wire capture = on & (mode == `MODE_CAPTURE) & cap_edge;
    wire single = pwm_like & (pin_fn == 2'h3);
    wire hit_a = step & match_a & (mode != `MODE_CAPTURE);
    // PWM counter never reaches the period value, so its P event is the wrap
    wire p_event = pwm_like ? (end_p & ~single) : match_p;
    wire hit_p = step & p_event & ~(((mode == `MODE_COMPARE) | (mode == `MODE_TIMER))
                                    & mode_q[`BIT_CLR_SEL]);

    always @(posedge clk) begin
        if (rst) begin
            count_q <= 10'h000;
            on_prev_q <= 1'b0;
        end else begin
            on_prev_q <= on;
            if (on_rise)
                count_q <= 10'h000;
            else if (step)
                count_q <= clr_now ? 10'h000 : count_q + 10'h001;
        end
    end

    // Output level before polarity
    always @(posedge clk) begin
        if (rst) begin
            level_q <= 1'b0;
        end else if (mode == `MODE_COMPARE) begin
            if (on_rise)
                level_q <= lvl;
            else if (hit_a) begin
                case (pin_fn)
                    2'h1:    level_q <= 1'b0;
                    2'h2:    level_q <= 1'b1;
                    2'h3:    level_q <= ~level_q;
                    default: level_q <= level_q;
                endcase
            end
        end else if (pwm_like) begin
            case (pin_fn)
                2'h0:    level_q <= ~lvl;
                2'h1:    level_q <= lvl;
                2'h2:    level_q <= (on & ((count_q < cmp_a_q) |
                                     ((period_q != 10'h000) & (cmp_a_q >= period_q))))
                                    ? lvl : ~lvl;
                default: level_q <= (on & ~(single & hit_a)) ? lvl : ~lvl;
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst)
            timer_output_pin <= 1'b0;
        else if (mode == `MODE_TIMER)
            timer_output_pin <= 1'b0;
        else
            timer_output_pin <= level_q ^ inv;
    end

    // Registers; single pulse end drops counter-on itself
    always @(posedge clk) begin
        if (rst) begin
            run_q <= `CTRL_RESET;
            mode_q <= `CTRL_RESET;
            cmp_a_q <= 10'h000;
            period_q <= 10'h000;
            compare_a_flag <= 1'b0;
            compare_p_flag <= 1'b0;
        end else begin
            if (wr_en & (paddr == `ADDR_RUN_CLOCK_CTRL))
                run_q <= {pwdata[7:3], 3'h0};
            else if (single & hit_a)
                run_q[`BIT_ON] <= 1'b0;
            else if (single & ~on & ck_rise)
                run_q[`BIT_ON] <= 1'b1;
            if (wr_en & (paddr == `ADDR_MODE_CTRL))
                mode_q <= pwdata[7:0];
            if (capture)
                cmp_a_q <= count_q;
            else if (wr_en & (paddr == `ADDR_CMP_A_LOW))
                cmp_a_q[7:0] <= pwdata[7:0];
            else if (wr_en & (paddr == `ADDR_CMP_A_HIGH))
                cmp_a_q[9:8] <= pwdata[1:0];
            if (wr_en & (paddr == `ADDR_PERIOD_LOW))
                period_q[7:0] <= pwdata[7:0];
            else if (wr_en & (paddr == `ADDR_PERIOD_HIGH))
                period_q[9:8] <= pwdata[1:0];
            // Set wins over a same-cycle write-one clear
            if (hit_a | capture)
                compare_a_flag <= 1'b1;
            else if (wr_en & (paddr == `ADDR_FLAGS) & pwdata[`BIT_FLAG_A])
                compare_a_flag <= 1'b0;
            if (hit_p)
                compare_p_flag <= 1'b1;
            else if (wr_en & (paddr == `ADDR_FLAGS) & pwdata[`BIT_FLAG_P])
                compare_p_flag <= 1'b0;
        end
    end

    // Read word, registered in the setup phase so it stands through access
    function [31:0] rd_word;
        input [11:0] addr;
        begin
            case (addr)
                `ADDR_RUN_CLOCK_CTRL: rd_word = {24'h000000, run_q};
                `ADDR_MODE_CTRL:      rd_word = {24'h000000, mode_q};
                `ADDR_COUNT_LOW:      rd_word = {24'h000000, count_q[7:0]};
                `ADDR_COUNT_HIGH:     rd_word = {30'h00000000, count_q[9:8]};
                `ADDR_CMP_A_LOW:      rd_word = {24'h000000, cmp_a_q[7:0]};
                `ADDR_CMP_A_HIGH:     rd_word = {30'h00000000, cmp_a_q[9:8]};
                `ADDR_PERIOD_LOW:     rd_word = {24'h000000, period_q[7:0]};
                `ADDR_PERIOD_HIGH:    rd_word = {30'h00000000, period_q[9:8]};
                `ADDR_FLAGS:          rd_word = {30'h00000000, compare_p_flag, compare_a_flag};
                default:              rd_word = 32'h00000000;
            endcase
        end
    endfunction

    always @(posedge clk) begin
        if (rst)
            prdata <= 32'h00000000;
        else if (psel & ~penable & ~pwrite)
            prdata <= rd_word(paddr);
    end
endmodule // periodic_timer
`default_nettype wire

// ---- core/periodic_timer_regs.vh ----
// Register offsets, field positions and reset values of the periodic timer
`ifndef PERIODIC_TIMER_REGS_VH
`define PERIODIC_TIMER_REGS_VH
`define ADDR_RUN_CLOCK_CTRL   12'h000
`define ADDR_MODE_CTRL        12'h004
`define ADDR_COUNT_LOW        12'h008
`define ADDR_COUNT_HIGH       12'h00C
`define ADDR_CMP_A_LOW        12'h010
`define ADDR_CMP_A_HIGH       12'h014
`define ADDR_PERIOD_LOW       12'h018
`define ADDR_PERIOD_HIGH      12'h01C
`define ADDR_FLAGS            12'h020
`define BIT_PAUSE             7
`define BIT_ON                3
`define BIT_OUT_LEVEL         3
`define BIT_INVERT            2
`define BIT_CAP_SRC           1
`define BIT_CLR_SEL           0
`define BIT_FLAG_A            0
`define BIT_FLAG_P            1
`define CTRL_RESET            8'h00
`define MODE_COMPARE          2'h0
`define MODE_CAPTURE          2'h1
`define MODE_PWM              2'h2
`define MODE_TIMER            2'h3
`define DIV_SYS               10'h004
`define DIV_HIGH_16           10'h010
`define DIV_HIGH_64           10'h040
`endif

// ---- sim/periodic_pins.sv ----
// Model of the clock and capture pins driven from outside
`timescale 1ns/1ps
`default_nettype none
module periodic_pins (
    input  wire logic clk,
    output var logic  external_count_pin,
    output var logic  capture_input_pin
);
    initial begin
        external_count_pin = 1'b0;
        capture_input_pin = 1'b0;
    end
    // Held four cycles each way so the synchroniser sees every edge
    task automatic pulse(input logic on_cap);
        @(posedge clk);
        if (on_cap)
            capture_input_pin <= 1'b1;
        else
            external_count_pin <= 1'b1;
        repeat (4) @(posedge clk);
        capture_input_pin <= 1'b0;
        external_count_pin <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule // periodic_pins
`default_nettype wire

// ---- sim/periodic_timer_10bit_tb.sv ----
// Self-checking bench for the periodic timer
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_10bit_tb;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        external_count_pin, capture_input_pin, timer_output_pin;
    logic        compare_a_flag, compare_p_flag;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          n;
    periodic_timer dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .external_count_pin, .capture_input_pin, .timer_output_pin,
        .compare_a_flag, .compare_p_flag);
    periodic_pins pins (.clk, .external_count_pin, .capture_input_pin);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic test_done;
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic ok;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Sampled mid-cycle, the value that stands at the access edge
        do begin
            @(negedge clk);
            rd = prdata;
            ok = pready;
            @(posedge clk);
        end while (ok !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("register %h", a), e, rd);
    endtask
    task automatic s_regs;
        for (int i = 0; i < 9; i++) rdc(12'(i * 4), 32'h0);
        rdc(12'h030, 32'h0);
        apb(1'b1, 12'h000, 32'hFF);
        rdc(12'h000, 32'hF8);
        apb(1'b1, 12'h008, 32'hFF);
        rdc(12'h008, 32'h0);
        apb(1'b1, 12'h014, 32'hFF);
        rdc(12'h014, 32'h3);
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b1, 12'h010, 32'h14);
    endtask
    // Compare-A at 20, clear on A, system clock
    task automatic s_cmp(input logic [7:0] c1, input logic exp);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h020, 32'h3);
        apb(1'b1, 12'h004, {24'h0, c1});
        apb(1'b1, 12'h000, 32'h18);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("pin initial", (c1[7:6] != 2'h3) & (c1[3] ^ c1[2]), timer_output_pin);
        n = 0;
        while (compare_a_flag !== 1'b1 && n < 40) @(posedge clk) n++;
        repeat (2) @(posedge clk);
        chk("flag A", 1, compare_a_flag);
        chk("pin after match", exp, timer_output_pin);
        chk("flag P", 0, compare_p_flag);
        apb(1'b0, 12'h008, 32'h0);
        chk("count bound", 1, rd <= 32'd20);
    endtask
    task automatic s_run;
        logic [31:0] v;
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h98);
        rdc(12'h008, 32'h0);
        apb(1'b1, 12'h000, 32'h18);
        repeat (30) @(posedge clk);
        apb(1'b1, 12'h000, 32'h98);
        apb(1'b0, 12'h008, 32'h0);
        v = rd;
        repeat (10) @(posedge clk);
        rdc(12'h008, v);
        apb(1'b1, 12'h000, 32'h10);
        rdc(12'h008, v);
        chk("count ran", 1, v > 32'd30);
    endtask
    task automatic s_ext(input logic [7:0] c0);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h000, {24'h0, c0});
        repeat (5) pins.pulse(1'b0);
        rdc(12'h008, 32'h5);
    endtask
    task automatic s_cap(input logic [7:0] c1, input logic exp);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h020, 32'h3);
        apb(1'b1, 12'h014, 32'h3);
        apb(1'b1, 12'h004, {24'h0, c1});
        apb(1'b1, 12'h000, 32'h18);
        pins.pulse(~c1[1]);
        chk("capture flag", exp, compare_a_flag);
        rdc(12'h014, exp ? 32'h0 : 32'h3);
    endtask
    // Period 4, high cycles counted over ten periods
    task automatic s_pwm(input logic [7:0] c1, input logic [31:0] cmpa, input int exp);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h020, 32'h3);
        apb(1'b1, 12'h010, cmpa);
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b1, 12'h018, 32'h4);
        apb(1'b1, 12'h004, {24'h0, c1});
        apb(1'b1, 12'h000, 32'h18);
        repeat (4) @(posedge clk);
        n = 0;
        repeat (40) @(posedge clk) n += (timer_output_pin === 1'b1);
        chk("pwm high cycles", exp, n);
        chk("pwm flag P", 1, compare_p_flag);
    endtask
    task automatic s_single;
        apb(1'b1, 12'h000, 32'h10);
        apb(1'b1, 12'h010, 32'h28);
        apb(1'b1, 12'h004, 32'hB8);
        pins.pulse(1'b0);
        chk("pulse active", 1, timer_output_pin);
        rdc(12'h000, 32'h18);
        repeat (50) @(posedge clk);
        rdc(12'h000, 32'h10);
        chk("pulse over", 0, timer_output_pin);
    endtask
    initial begin
        #3_000_000;
        error_cnt++;
        test_done;
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        s_regs;
        s_cmp(8'h11, 1'b0);
        s_cmp(8'h21, 1'b1);
        s_cmp(8'h31, 1'b1);
        s_cmp(8'h01, 1'b0);
        s_cmp(8'h25, 1'b0);
        s_cmp(8'h29, 1'b1);
        s_cmp(8'hC1, 1'b0);
        s_run;
        s_ext(8'h68);
        s_ext(8'h78);
        s_cap(8'h40, 1'b1);
        s_cap(8'h42, 1'b1);
        s_cap(8'h70, 1'b0);
        s_pwm(8'hA8, 32'h2, 20);
        s_pwm(8'hA8, 32'h5, 40);
        s_pwm(8'hA0, 32'h1, 30);
        s_pwm(8'h88, 32'h2, 0);
        s_pwm(8'h98, 32'h2, 40);
        s_single;
        test_done;
    end
endmodule // periodic_timer_10bit_tb
`default_nettype wire

// ---- sim/periodic_timer_assertions.sv ----
// Port checks for the periodic timer
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_assertions (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        timer_output_pin,
    input wire logic        compare_a_flag,
    input wire logic        compare_p_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] mode_q;
    wire        rd = psel && penable && !pwrite;
    wire        wr = psel && penable && pwrite;
    // Shadow of the mode register, taken on the access edge
    always @(posedge clk) begin
        if (rst)
            mode_q <= 8'h00;
        else if (wr && paddr == 12'h004)
            mode_q <= pwdata[7:0];
    end
    property p_answer; pready && !pslverr; endproperty
    a_answer: assert property (p_answer) else $error("bus answer wrong");
    property p_c0_low; rd && paddr == 12'h000 |-> prdata[2:0] == 3'h0; endproperty
    a_c0_low: assert property (p_c0_low) else $error("control low bits set");
    property p_cnt_hi; rd && paddr == 12'h00C |-> prdata[31:2] == 30'h0; endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("count high byte too wide");
    property p_mode_rd; rd && paddr == 12'h004 |-> prdata[7:0] == mode_q; endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
    property p_rst; $fell(rst) |-> !compare_a_flag && !compare_p_flag && !timer_output_pin;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_tmr; (mode_q[7:6] == 2'h3) [*3] |-> !timer_output_pin; endproperty
    a_tmr: assert property (p_tmr) else $error("pin used in timer mode");
    property p_hold; compare_a_flag && !(wr && paddr == 12'h020 && pwdata[0]) |=> compare_a_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("flag A dropped");
    property p_nop; (mode_q[7:6] == 2'h0 && mode_q[0] && !compare_p_flag) [*3] |=> !compare_p_flag;
    endproperty
    a_nop: assert property (p_nop) else $error("flag P raised with clear on A");
endmodule // periodic_timer_assertions
bind periodic_timer periodic_timer_assertions chk_i (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .timer_output_pin, .compare_a_flag,
    .compare_p_flag);
`default_nettype wire
